// ==== src/nmd_regs.svh ====
// register map, field positions and timing counts for the diagnostics block
`ifndef NMD_REGS_SVH
`define NMD_REGS_SVH
`define NMD_CLK_NS 100
`define NMD_TICK_NS 1000000
`define NMD_TICK_CYC (`NMD_TICK_NS / `NMD_CLK_NS)
`define NMD_ADDR_CTRL 8'h00
`define NMD_ADDR_RUNG 8'h04
`define NMD_ADDR_DIAG 8'h08
`define NMD_CTRL_LCHK 0
`define NMD_CTRL_INIT 1
`define NMD_RS_CONT 21
`define NMD_RS_SENT 16
`define NMD_RS_DONE 15
`define NMD_RS_RUN 14
`define NMD_RS_ERR_W 14
`define NMD_ERR_MAX 14'h3E80
`define NMD_ERR_ADDR 14'h0003
`define NMD_ERR_OPER 14'h0005
`define NMD_ERR_PROT 14'h0007
`define NMD_ERR_RDONLY 14'h0009
`define NMD_ERR_LINK 14'h000D
`define NMD_ERR_OVFL 14'h000F
`define NMD_ERR_INACT 14'h0011
`define NMD_ERR_COUNT 14'h0013
`define NMD_ERR_FENCE 14'h0017
`define NMD_ERR_ROUTE 14'h001D
`define NMD_FLT_PROM 3'h1
`define NMD_FLT_DRAM 3'h2
`define NMD_FLT_SER 3'h3
`define NMD_FLT_NET 3'h4
`define NMD_SW_TEST_BIT 6
`define NMD_LCHK_MS 11'h7D0
`define NMD_POST_MS 17'h007D0
`define NMD_POST_STEP_MS 10'h0FA
`define NMD_FL_SLOT_MS 10'h1F4
`define NMD_FL_ON_MS 10'h0FA
`define NMD_FL_PAUSE 3'h2
`define NMD_EXT_PAIR_MS 10'h2EE
`define NMD_EXT_NET_MS 11'h753
`define NMD_EXT_NET_AT 17'h124F8
`define NMD_EXT_ALL_MS 17'h15F90
`endif

// ==== src/nmd_pkg.sv ====
// types shared by the diagnostics block
`default_nettype none
package nmd_pkg;
  typedef enum logic [2:0] {ST_SYNC, ST_POST, ST_RUN, ST_EXT, ST_FAULT} nmd_state_e;
  typedef logic [16:0] nmd_ms_t;
endpackage
`default_nettype wire

// ==== src/nmd_diag.sv ====
// network module diagnostics: indicators, link check, self test, rung status
// Operation
// - light port transmit indicator while sending
// - light port receive indicator while receiving
// - link check every two seconds per port
// - issue link check only when port idle
// - send inquiry, attached device replies
// - inquiry runs without user program
// - power-up self test flashes network indicators
// - indicators off after pass, then operate
// - fault halts start-up, flash code forever
// - flash count encodes the fault source
// - extended test alternates port pairs, errors flash
// - network toggles four times, repeat cycle
// - extended test error gives flash code
// - result 1 to 16000 is error code
// - access error codes as listed
// - link error codes as listed
// - set sent bit, then done bit
// - continuity, remote run and error fields
// - rung opened clears its status
`include "nmd_regs.svh"
`default_nettype none
module nmd_diag #(
  parameter int TICK_CYC = `NMD_TICK_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial port activity
  input wire logic [1:0] port_busy,
  input wire logic [1:0] port_tx_active,
  input wire logic [1:0] port_rx_active,
  output logic [1:0] inquiry_req,
  // network port activity
  input wire logic net_activity,
  input wire logic net_rx_error,
  input wire logic net_tx_error,
  // self test
  input wire logic [7:0] port1_switch_group,
  input wire logic [2:0] st_fault_code,
  // communication rung events
  input wire logic rung_sent,
  input wire logic rung_done,
  input wire logic rung_remote_run,
  input wire logic rung_err_valid,
  input wire logic [13:0] rung_err_code,
  // indicators
  output logic port0_receive_indicator,
  output logic port0_transmit_indicator,
  output logic port1_receive_indicator,
  output logic port1_transmit_indicator,
  output logic net_rx_led,
  output logic net_tx_led,
  output logic network_led
);
  nmd_pkg::nmd_state_e state_ff, nxt_state;
  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  logic [2:0] sw_sync_ff;
  logic [1:0] sync_cnt_ff;
  logic ext_sel_ff;
  logic [1:0] ctrl_ff;
  logic [31:0] rung_ff, nxt_rung;
  logic [2:0] fault_ff;
  nmd_pkg::nmd_ms_t ms_ff;
  logic [10:0] sub_ff;
  logic half_ff;
  logic [2:0] fl_idx_ff;
  logic [1:0] inq_ff;
  logic [3:0] port_led_ff;
  logic net_rx_ff, net_tx_ff, net_led_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  // switch value trusted only once the pin has filled all three stages
  wire sw_ready = (sync_cnt_ff == 2'h3) && (sw_sync_ff[1] == sw_sync_ff[2]);

  // apb decode
  wire apb_acc = psel & penable & ~pready_ff;
  wire apb_done = psel & penable & pready_ff;
  wire sel_ctrl = (paddr == `NMD_ADDR_CTRL);
  wire sel_rung = (paddr == `NMD_ADDR_RUNG);
  wire sel_diag = (paddr == `NMD_ADDR_DIAG);
  wire addr_ok = sel_ctrl | sel_rung | sel_diag;
  wire ctrl_wr = apb_done & pwrite & sel_ctrl;
  wire [31:0] diag_word = {23'h000000, ext_sel_ff, 1'b0, fault_ff, 1'b0, state_ff};
  wire [31:0] rd_mux = sel_ctrl ? {30'h00000000, ctrl_ff} :
                       sel_rung ? rung_ff :
                       sel_diag ? diag_word : 32'h00000000;

  // registered apb answer, one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= apb_acc;
      pslverr_ff <= apb_acc & ~addr_ok;
      prdata_ff <= (apb_acc & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // control register: link check enable and rung initiating contact
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= 2'h0;
    else if (ctrl_wr)
      ctrl_ff <= pwdata[1:0];
  end

  wire lchk_en = ctrl_ff[`NMD_CTRL_LCHK];
  wire rung_init = ctrl_ff[`NMD_CTRL_INIT];

  // millisecond tick divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1));
      tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1)) ? 32'h00000000 : tick_cnt_ff + 32'h1;
    end
  end

  // test switch synchroniser, caught once after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_sync_ff <= 3'h7;
      sync_cnt_ff <= 2'h0;
      ext_sel_ff <= 1'b0;
    end
    else
    begin
      sw_sync_ff <= {sw_sync_ff[1:0], port1_switch_group[`NMD_SW_TEST_BIT]};
      if (sync_cnt_ff != 2'h3)
        sync_cnt_ff <= sync_cnt_ff + 2'h1;
      if (state_ff == nmd_pkg::ST_SYNC && sw_ready)
        ext_sel_ff <= ~sw_sync_ff[2];
    end
  end

  // rung status word
  wire err_ok = rung_err_valid && rung_err_code != 14'h0000 && rung_err_code <= `NMD_ERR_MAX;
  always_comb
  begin
    nxt_rung = rung_ff;
    if (!rung_init)
      nxt_rung = 32'h00000000;
    else
    begin
      nxt_rung[`NMD_RS_CONT] = 1'b1;
      nxt_rung[`NMD_RS_RUN] = rung_remote_run;
      if (rung_sent)
        nxt_rung[`NMD_RS_SENT] = 1'b1;
      if (rung_done)
        nxt_rung[`NMD_RS_DONE] = 1'b1;
      if (err_ok)
        nxt_rung[`NMD_RS_ERR_W-1:0] = rung_err_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rung_ff <= 32'h00000000;
    else
      rung_ff <= nxt_rung;
  end

  // sequence timing terms
  wire ext_st = (state_ff == nmd_pkg::ST_EXT);
  wire post_end = (state_ff == nmd_pkg::ST_POST) && (ms_ff == `NMD_POST_MS - 17'h1);
  wire ext_wrap = ext_st && (ms_ff == `NMD_EXT_ALL_MS - 17'h1);
  wire ext_net = (ms_ff >= `NMD_EXT_NET_AT);
  wire [10:0] sub_lim = (state_ff == nmd_pkg::ST_POST) ? {1'b0, `NMD_POST_STEP_MS} :
                        (state_ff == nmd_pkg::ST_FAULT) ? {1'b0, `NMD_FL_SLOT_MS} :
                        ext_net ? `NMD_EXT_NET_MS : {1'b0, `NMD_EXT_PAIR_MS};
  wire sub_end = (sub_ff == sub_lim - 11'h1);
  wire fault_seen = (st_fault_code != 3'h0);

  // start-up and test state machine
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      nmd_pkg::ST_SYNC:
        if (sw_ready)
          nxt_state = ~sw_sync_ff[2] ? nmd_pkg::ST_EXT : nmd_pkg::ST_POST;
      nmd_pkg::ST_POST:
        if (fault_seen)
          nxt_state = nmd_pkg::ST_FAULT;
        else if (tick_ff && post_end)
          nxt_state = nmd_pkg::ST_RUN;
      nmd_pkg::ST_EXT:
        if (fault_seen)
          nxt_state = nmd_pkg::ST_FAULT;
      nmd_pkg::ST_RUN:
        nxt_state = nmd_pkg::ST_RUN;
      nmd_pkg::ST_FAULT:
        nxt_state = nmd_pkg::ST_FAULT;
      default:
        nxt_state = nmd_pkg::ST_FAULT;
    endcase
  end

  // state, fault code and sequence counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= nmd_pkg::ST_SYNC;
      fault_ff <= 3'h0;
      ms_ff <= 17'h0;
      sub_ff <= 11'h0;
      half_ff <= 1'b0;
      fl_idx_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (nxt_state == nmd_pkg::ST_FAULT && state_ff != nmd_pkg::ST_FAULT)
      begin
        fault_ff <= st_fault_code;
        sub_ff <= 11'h0;
        fl_idx_ff <= 3'h0;
      end
      else if (state_ff == nmd_pkg::ST_SYNC)
      begin
        ms_ff <= 17'h0;
        sub_ff <= 11'h0;
        half_ff <= 1'b0;
      end
      else if (tick_ff)
      begin
        ms_ff <= (ext_wrap || post_end) ? 17'h0 : ms_ff + 17'h1;
        sub_ff <= (sub_end || (ext_st && ms_ff == `NMD_EXT_NET_AT - 17'h1) || ext_wrap) ?
                  11'h0 : sub_ff + 11'h1;
        if (sub_end)
          half_ff <= ~half_ff;
        if (ext_wrap)
          half_ff <= 1'b0;
        if (sub_end && state_ff == nmd_pkg::ST_FAULT)
          fl_idx_ff <= (fl_idx_ff == fault_ff + `NMD_FL_PAUSE - 3'h1) ? 3'h0 : fl_idx_ff + 3'h1;
      end
    end
  end

  // flash code: n short joint flashes then a pause
  wire flash_on = (fl_idx_ff < fault_ff) && (sub_ff < {1'b0, `NMD_FL_ON_MS});
  wire run_st = (state_ff == nmd_pkg::ST_RUN);

  // link check per serial port
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_port
      logic [10:0] lchk_ms_ff;
      wire lchk_due = (lchk_ms_ff >= `NMD_LCHK_MS);
      wire port_idle = ~port_busy[gp] & ~port_tx_active[gp] & ~port_rx_active[gp];
      wire fire = run_st & lchk_en & lchk_due & port_idle & ~inq_ff[gp];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          lchk_ms_ff <= 11'h0;
          inq_ff[gp] <= 1'b0;
        end
        else
        begin
          inq_ff[gp] <= fire;
          if (fire || !lchk_en)
            lchk_ms_ff <= 11'h0;
          else if (tick_ff && !lchk_due)
            lchk_ms_ff <= lchk_ms_ff + 11'h1;
        end
      end
    end
  endgenerate

  // indicator drive per state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_led_ff <= 4'h0;
      net_rx_ff <= 1'b0;
      net_tx_ff <= 1'b0;
      net_led_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        nmd_pkg::ST_RUN:
        begin
          port_led_ff <= {port_tx_active[1] | inq_ff[1], port_rx_active[1],
                          port_tx_active[0] | inq_ff[0], port_rx_active[0]};
          net_rx_ff <= net_rx_error;
          net_tx_ff <= net_tx_error;
          net_led_ff <= net_activity;
        end
        nmd_pkg::ST_POST:
        begin
          port_led_ff <= 4'h0;
          net_rx_ff <= half_ff;
          net_tx_ff <= ~half_ff;
          net_led_ff <= 1'b0;
        end
        nmd_pkg::ST_EXT:
        begin
          port_led_ff <= ext_net ? 4'h0 : (half_ff ? 4'h3 : 4'hC);
          net_rx_ff <= half_ff;
          net_tx_ff <= half_ff;
          net_led_ff <= ext_net & half_ff;
        end
        nmd_pkg::ST_FAULT:
        begin
          port_led_ff <= 4'h0;
          net_rx_ff <= flash_on;
          net_tx_ff <= flash_on;
          net_led_ff <= 1'b0;
        end
        default:
        begin
          port_led_ff <= 4'h0;
          net_rx_ff <= 1'b0;
          net_tx_ff <= 1'b0;
          net_led_ff <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign inquiry_req = inq_ff;
  assign port0_receive_indicator = port_led_ff[0];
  assign port0_transmit_indicator = port_led_ff[1];
  assign port1_receive_indicator = port_led_ff[2];
  assign port1_transmit_indicator = port_led_ff[3];
  assign net_rx_led = net_rx_ff;
  assign net_tx_led = net_tx_ff;
  assign network_led = net_led_ff;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sent;
    rung_init && rung_sent;
  endsequence
  sequence s_done_later;
    ##[1:20] (rung_init && rung_done) ##1 rung_ff[`NMD_RS_DONE];
  endsequence

  chk_rung_clear: assert property (!rung_init |=> rung_ff == 32'h0)
    else $error("rung status not cleared");
  chk_rung_cont: assert property (rung_init |=> rung_ff[`NMD_RS_CONT])
    else $error("continuity bit missing");
  chk_sent_bit: assert property (s_sent |=> rung_ff[`NMD_RS_SENT])
    else $error("sent bit missing");
  chk_sent_done: assert property (s_sent ##0 rung_init[*1] ##0 s_done_later
                                  |-> rung_ff[`NMD_RS_SENT])
    else $error("done without sent");
  chk_err_load: assert property (rung_init && err_ok |=>
                                 rung_ff[13:0] == $past(rung_err_code))
    else $error("error code not stored");
  chk_inq_idle: assert property (inquiry_req[0] |-> !$past(port_busy[0]) && $past(lchk_en))
    else $error("inquiry while busy");
  chk_inq_gap: assert property ($rose(inquiry_req[1]) |=> !inquiry_req[1] [*8])
    else $error("inquiry repeated too soon");
  chk_run_quiet: assert property (run_st && !net_rx_error && !net_tx_error |=>
                                  !net_rx_led && !net_tx_led)
    else $error("network lights on in operation");
  chk_fault_hold: assert property (state_ff == nmd_pkg::ST_FAULT |=>
                                   state_ff == nmd_pkg::ST_FAULT && $stable(fault_ff))
    else $error("fault state left");
  chk_tx_led: assert property (run_st && port_tx_active[0] |=> port0_transmit_indicator)
    else $error("tx indicator dark");
  chk_rx_led: assert property (run_st && port_rx_active[1] |=> port1_receive_indicator)
    else $error("rx indicator dark");
  chk_switch_hold: assert property (state_ff != nmd_pkg::ST_SYNC |=> $stable(ext_sel_ff))
    else $error("test select changed");
  chk_fault_dark: assert property (state_ff == nmd_pkg::ST_FAULT && fl_idx_ff >= fault_ff
                                   |=> !net_rx_led)
    else $error("light on during pause");
endmodule
`default_nettype wire

// ==== test/nmd_port_peer.sv ====
// attached serial device model: answers each inquiry with a short reply
`default_nettype none
module nmd_port_peer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // reply speed, high = slow device
  input wire logic slow,
  // link to the block
  input wire logic [1:0] inquiry_req,
  output logic [1:0] port_rx_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_ff [2];
  // per port: wait a while after the inquiry, then reply for eight cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!presetn)
        cnt_ff[p] <= 6'h00;
      else if (inquiry_req[p])
        cnt_ff[p] <= slow ? 6'h28 : 6'h0C;
      else if (cnt_ff[p] != 6'h00)
        cnt_ff[p] <= cnt_ff[p] - 6'h01;
    end
  end
  // reply is visible only in the last eight counts
  always_comb
  begin
    for (int p = 0; p < 2; p++)
      port_rx_active[p] = (cnt_ff[p] != 6'h00) && (cnt_ff[p] <= 6'h08);
  end
endmodule
`default_nettype wire

// ==== test/nmd_diag_bench.sv ====
// self-checking bench for the network module diagnostics block
`include "nmd_regs.svh"
`default_nettype none
module nmd_diag_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCK = 4;
  // stimulus and observed signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rdv;
  logic pready, pslverr, erv, slow = 1'b0;
  logic [1:0] port_busy = 2'b00, port_tx_active = 2'b00, port_rx_active, inquiry_req;
  logic net_activity = 1'b0, net_rx_error = 1'b0, net_tx_error = 1'b0;
  logic [7:0] port1_switch_group = 8'hFF;
  logic [2:0] st_fault_code = 3'h0;
  logic rung_sent = 1'b0, rung_done = 1'b0, rung_remote_run = 1'b0, rung_err_valid = 1'b0;
  logic [13:0] rung_err_code = 14'h0000;
  logic port0_receive_indicator, port0_transmit_indicator;
  logic port1_receive_indicator, port1_transmit_indicator, net_rx_led, net_tx_led, network_led;
  int n_mismatch = 0, total_checks = 0;
  // device under test and the attached serial device
  nmd_diag #(.TICK_CYC(TCK)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .port_busy, .port_tx_active, .port_rx_active,
    .inquiry_req, .net_activity, .net_rx_error, .net_tx_error, .port1_switch_group,
    .st_fault_code, .rung_sent, .rung_done, .rung_remote_run, .rung_err_valid,
    .rung_err_code, .port0_receive_indicator, .port0_transmit_indicator,
    .port1_receive_indicator, .port1_transmit_indicator, .net_rx_led, .net_tx_led,
    .network_led);
  nmd_port_peer peer_u (.pclk, .presetn, .slow, .inquiry_req, .port_rx_active);
  // 10 MHz clock
  always #50 pclk = ~pclk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 16)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic do_reset(input logic [7:0] s, input logic [2:0] f);
    @(posedge pclk);
    presetn <= 1'b0;
    port1_switch_group <= s;
    st_fault_code <= f;
    tick(8);
    presetn <= 1'b1;
  endtask
  task automatic pulse_ev(input int k, input logic [13:0] c);
    @(posedge pclk);
    rung_sent <= (k == 0);
    rung_done <= (k == 1);
    rung_err_valid <= (k == 2);
    rung_err_code <= c;
    @(posedge pclk);
    {rung_sent, rung_done, rung_err_valid} <= 3'b000;
    apb(1'b0, `NMD_ADDR_RUNG, 32'h0);
  endtask
  // waits for an inquiry on port 0, returns one more than the edges waited
  task automatic wait_inq(input int lim, output int n);
    for (n = 1; n <= lim && inquiry_req[0] !== 1'b1; n++)
      @(posedge pclk);
    if (n > lim)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic t_post();
    logic seen, both;
    seen = 1'b0;
    both = 1'b0;
    do_reset(8'hFF, 3'h0);
    repeat (2100 * TCK)
    begin
      @(posedge pclk);
      seen |= net_rx_led | net_tx_led;
      both |= net_rx_led & net_tx_led;
    end
    chk(seen, 1);
    chk(both, 0);
    chk({net_rx_led, net_tx_led}, 0);
    apb(1'b0, `NMD_ADDR_DIAG, 32'h0);
    chk(rdv & 32'h107, 32'h2);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    chk(erv, 1);
    apb(1'b0, 8'h0C, 32'h0);
    chk({erv, rdv[30:0]}, 32'h80000000);
    $display("post test done");
  endtask
  task automatic t_rung();
    logic [13:0] codes [10] = '{`NMD_ERR_ADDR, `NMD_ERR_OPER, `NMD_ERR_PROT, `NMD_ERR_RDONLY,
      `NMD_ERR_COUNT, `NMD_ERR_FENCE, `NMD_ERR_LINK, `NMD_ERR_OVFL, `NMD_ERR_INACT,
      `NMD_ERR_ROUTE};
    apb(1'b1, `NMD_ADDR_RUNG, 32'hFFFFFFFF);
    apb(1'b1, `NMD_ADDR_CTRL, 32'h2);
    pulse_ev(3, 14'h0);
    chk(rdv, 32'h00200000);
    pulse_ev(0, 14'h0);
    chk(rdv, 32'h00210000);
    rung_remote_run <= 1'b1;
    pulse_ev(1, 14'h0);
    chk(rdv, 32'h0021C000);
    foreach (codes[i])
    begin
      pulse_ev(2, codes[i]);
      chk(rdv & 32'h3FFF, {18'h0, codes[i]});
    end
    pulse_ev(2, `NMD_ERR_MAX);
    chk(rdv & 32'h3FFF, {18'h0, `NMD_ERR_MAX});
    pulse_ev(2, `NMD_ERR_MAX + 14'h1);
    chk(rdv & 32'h3FFF, {18'h0, `NMD_ERR_MAX});
    apb(1'b1, `NMD_ADDR_CTRL, 32'h0);
    pulse_ev(3, 14'h0);
    chk(rdv, 32'h0);
    rung_remote_run <= 1'b0;
    $display("rung test done");
  endtask
  task automatic t_link();
    int n;
    logic hit, tx_seen, rx_seen;
    hit = 1'b0;
    @(posedge pclk);
    port_tx_active <= 2'b11;
    net_activity <= 1'b1;
    net_rx_error <= 1'b1;
    tick(3);
    chk({port1_transmit_indicator, port0_transmit_indicator}, 32'h3);
    chk({network_led, net_rx_led, net_tx_led}, 32'h6);
    port_tx_active <= 2'b00;
    net_activity <= 1'b0;
    net_rx_error <= 1'b0;
    repeat (2050 * TCK)
    begin
      @(posedge pclk);
      hit |= |inquiry_req;
    end
    chk(hit, 0);
    apb(1'b1, `NMD_ADDR_CTRL, 32'h1);
    for (int r = 0; r < 2; r++)
    begin
      wait_inq(2100 * TCK, n);
      chk(inquiry_req, 32'h3);
      if (r == 1)
        chk((n + 61 >= 1998 * TCK) && (n + 61 <= 2002 * TCK), 1);
      rx_seen = 1'b0;
      @(posedge pclk);
      chk(inquiry_req[0], 0);
      tx_seen = port0_transmit_indicator;
      repeat (60)
      begin
        @(posedge pclk);
        tx_seen |= port0_transmit_indicator;
        rx_seen |= port0_receive_indicator;
      end
      chk({tx_seen, rx_seen}, 32'h3);
    end
    port_busy <= 2'b01;
    slow <= 1'b1;
    hit = 1'b0;
    tx_seen = 1'b0;
    repeat (2100 * TCK)
    begin
      @(posedge pclk);
      hit |= inquiry_req[0];
      tx_seen |= inquiry_req[1];
    end
    chk({hit, tx_seen}, 32'h1);
    port_busy <= 2'b00;
    wait_inq(20, n);
    $display("link test done");
  endtask
  task automatic t_fault();
    logic [31:0] nrise;
    logic diff, prev;
    for (int c = 1; c <= 4; c++)
    begin
      do_reset(8'hFF, 3'(c));
      tick(50);
      apb(1'b0, `NMD_ADDR_DIAG, 32'h0);
      chk(rdv & 32'h77, {25'h0, 3'(c), 4'h4});
      nrise = 32'h0;
      diff = 1'b0;
      prev = net_rx_led;
      repeat ((c * 500 + 1000) * TCK)
      begin
        @(posedge pclk);
        nrise += {31'h0, net_rx_led & ~prev};
        diff |= net_rx_led ^ net_tx_led;
        prev = net_rx_led;
      end
      chk(nrise, 32'(c));
      chk(diff, 0);
    end
    $display("fault test done");
  endtask
  task automatic t_ext();
    logic [1:0] seen;
    seen = 2'b00;
    do_reset(8'hBF, 3'h0);
    tick(375 * TCK);
    apb(1'b0, `NMD_ADDR_DIAG, 32'h0);
    chk(rdv & 32'h107, 32'h103);
    chk({port1_transmit_indicator, port1_receive_indicator, port0_transmit_indicator,
      port0_receive_indicator}, 32'hC);
    repeat (750 * TCK)
    begin
      @(posedge pclk);
      seen |= {net_rx_led, net_tx_led};
    end
    chk({port1_transmit_indicator, port1_receive_indicator, port0_transmit_indicator,
      port0_receive_indicator}, 32'h3);
    chk(seen, 32'h3);
    port1_switch_group <= 8'hFF;
    tick(100);
    apb(1'b0, `NMD_ADDR_DIAG, 32'h0);
    chk(rdv & 32'h107, 32'h103);
    $display("extended test done");
  endtask
  // main sequence
  initial
  begin
    t_post();
    t_rung();
    t_link();
    t_fault();
    t_ext();
    conclude();
  end
endmodule
`default_nettype wire
